// [rtc_flags_status_trim_defs.svh]
/*
 Register indices, bit positions, reset values and timing counts of the
 real-time counter register block. Assumes inclusion by bare name only.
*/
`ifndef RTC_FLAGS_STATUS_TRIM_DEFS_SVH
`define RTC_FLAGS_STATUS_TRIM_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL        6'h00
`define IDX_IRQ_CLR     6'h06
`define IDX_IRQ_SET     6'h07
`define IDX_FLAGS       6'h08
`define IDX_SYNC        6'h0a
`define IDX_HALT        6'h0b
`define IDX_TRIM        6'h0c
`define IDX_COUNT       6'h10
`define IDX_ALARM       6'h18

// Field positions
`define BIT_OVF         7
`define BIT_SYNC_RDY    6
`define BIT_ALARM_ZERO  0
`define BIT_BUSY        7
`define BIT_RUN_HALT    0
`define BIT_SIGN        7
`define BIT_SWRST       0
`define BIT_ENABLE      1

// Reset values
`define RST_BYTE        8'h00
`define RST_WORD        32'h0000_0000
`define FLAG_MASK       8'hc1

// Timing: counter-domain rate derived from mclk, rounded down
`define MCLK_HZ         200000000
`define COUNTER_CLK_HZ  32768
`define TRIM_WINDOW     128

`endif

// [rtc_trim_pkg.sv]
/*
 Types shared by the real-time counter register block.
 Assumes the defs header supplies all numeric constants.
*/
package rtc_trim_pkg;

	typedef enum logic [2:0] {
		SYNC_IDLE  = 3'h1,
		SYNC_WAIT  = 3'h2,
		SYNC_APPLY = 3'h4
	} sync_state_t;

	typedef enum logic [3:0] {
		CAUSE_COUNT  = 4'h1,
		CAUSE_TRIM   = 4'h2,
		CAUSE_ENABLE = 4'h4,
		CAUSE_SWRST  = 4'h8
	} sync_cause_t;

endpackage

// [rtc_flags_status_trim.sv]
/*
 Register side of a real-time counter: APB slave, write-one-to-clear flags,
 interrupt enables, sync-busy status, halt-in-debug control, prescaler trim
 and the 32-bit counter. Assumes one clock mclk, APB master on mclk, and a
 debug-halt level generated on mclk.
*/
`timescale 1ns/1ps
`include "rtc_flags_status_trim_defs.svh"

// Overview of operation
// - Overflow flag set one counter tick later
// - Writing one clears overflow flag
// - Sync-ready set when busy falls, except enable/reset
// - Writing one clears sync-ready flag
// - Alarm flag set one tick after match
// - Writing one clears alarm flag
// - Writing zero leaves any flag unchanged
// - Interrupt raised while flag and enable set
// - Busy set when cross-domain transfer starts
// - Busy cleared when transfer completes
// - Run-in-halt survives software reset
// - Halt counting in debug unless run-in-halt
// - Run-in-halt keeps counting during debug
// - Sign zero slows, sign one speeds
// - Magnitude scales prescaler correction proportionally
// - Magnitude zero means no correction
// - Writing one to enable-set sets enable
module rtc_flags_status_trim
	import rtc_trim_pkg::*;
#(
	parameter int PRESC_DIV = `MCLK_HZ / `COUNTER_CLK_HZ
) (
	input  wire  logic        mclk,
	input  wire  logic        rst_b,
	input  wire  logic        psel,
	input  wire  logic        penable,
	input  wire  logic        pwrite,
	input  wire  logic [7:0]  paddr,
	input  wire  logic [31:0] pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire  logic        cpuDebugHalt,
	output logic              irq
);

	function automatic logic regHit(input logic [7:0] addr, input logic [5:0] idx);
		regHit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
	endfunction

	logic [31:0]  count;
	logic [31:0]  alarmZero;
	logic [7:0]   rateTrim;
	logic [7:0]   flags;
	logic [7:0]   irqEnable;
	logic [7:0]   flagSet;
	logic         runInHalt;
	logic         enabled;
	logic         readyReg;
	logic         wrEn;
	logic         setup;
	logic [31:0]  next_prdata;
	logic         next_pslverr;
	logic [15:0]  prescCnt;
	logic [15:0]  curPeriod;
	logic [6:0]   windowCnt;
	logic         counterTick;
	logic         counting;
	logic         ovfPend;
	logic         alarmPend;
	sync_state_t  syncState;
	sync_cause_t  syncCause;
	logic [31:0]  pendValue;
	logic         syncStart;
	logic         busy;
	logic         busyPrev;
	logic         applyNow;
	logic         swrstApply;
	logic         quietCause;

	// APB: no wait state; read data is registered from flip-flops in the setup phase
	assign setup  = psel && !penable;
	assign pready = readyReg;
	assign wrEn   = psel && penable && readyReg && pwrite;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			readyReg <= 1'b0;
		end else begin
			readyReg <= setup;
		end
	end

	always_comb begin
		next_prdata  = `RST_WORD;
		next_pslverr = 1'b0;
		if (regHit(paddr, `IDX_CTRL)) begin
			next_prdata[`BIT_ENABLE] = enabled;
			next_prdata[`BIT_SWRST]  = busy && (syncCause == CAUSE_SWRST);
		end else if (regHit(paddr, `IDX_IRQ_CLR) || regHit(paddr, `IDX_IRQ_SET)) begin
			next_prdata[7:0] = irqEnable;
		end else if (regHit(paddr, `IDX_FLAGS)) begin
			next_prdata[7:0] = flags;
		end else if (regHit(paddr, `IDX_SYNC)) begin
			next_prdata[`BIT_BUSY] = busy;
		end else if (regHit(paddr, `IDX_HALT)) begin
			next_prdata[`BIT_RUN_HALT] = runInHalt;
		end else if (regHit(paddr, `IDX_TRIM)) begin
			next_prdata[7:0] = rateTrim;
		end else if (regHit(paddr, `IDX_COUNT)) begin
			next_prdata = count;
		end else if (regHit(paddr, `IDX_ALARM)) begin
			next_prdata = alarmZero;
		end else begin
			next_pslverr = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			prdata  <= `RST_WORD;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? `RST_WORD : next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// Prescaler with trim: a slower rate stretches the first N ticks of each window
	always_comb begin
		curPeriod = 16'(PRESC_DIV);
		if (rateTrim[6:0] != 7'h00 && windowCnt < rateTrim[6:0]) begin
			curPeriod = rateTrim[`BIT_SIGN] ? 16'(PRESC_DIV - 1) : 16'(PRESC_DIV + 1);
		end
	end

	assign counterTick = (prescCnt == curPeriod - 16'h0001);

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			prescCnt  <= 16'h0000;
			windowCnt <= 7'h00;
		end else if (counterTick) begin
			prescCnt  <= 16'h0000;
			windowCnt <= windowCnt + 7'h01;
		end else begin
			prescCnt <= prescCnt + 16'h0001;
		end
	end

	// Counting gated by enable and debug halt
	assign counting = enabled && (!cpuDebugHalt || runInHalt);

	// Cross-domain transfer: committed on the second counter tick
	assign syncStart = wrEn && (syncState == SYNC_IDLE) && (regHit(paddr, `IDX_COUNT)
		|| regHit(paddr, `IDX_TRIM) || regHit(paddr, `IDX_CTRL));
	assign busy       = (syncState != SYNC_IDLE);
	assign applyNow   = counterTick && (syncState == SYNC_APPLY);
	assign swrstApply = applyNow && (syncCause == CAUSE_SWRST);
	assign quietCause = (syncCause == CAUSE_ENABLE) || (syncCause == CAUSE_SWRST);

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			syncState <= SYNC_IDLE;
			syncCause <= CAUSE_COUNT;
			pendValue <= `RST_WORD;
		end else begin
			case (syncState)
				SYNC_IDLE: begin
					if (syncStart) begin
						syncState <= SYNC_WAIT;
						pendValue <= pwdata;
						if (regHit(paddr, `IDX_COUNT)) begin
							syncCause <= CAUSE_COUNT;
						end else if (regHit(paddr, `IDX_TRIM)) begin
							syncCause <= CAUSE_TRIM;
						end else if (pwdata[`BIT_SWRST]) begin
							syncCause <= CAUSE_SWRST;
						end else begin
							syncCause <= CAUSE_ENABLE;
						end
					end
				end
				SYNC_WAIT: begin
					if (counterTick) begin
						syncState <= SYNC_APPLY;
					end
				end
				SYNC_APPLY: begin
					if (counterTick) begin
						syncState <= SYNC_IDLE;
					end
				end
				default: begin
					syncState <= SYNC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			busyPrev <= 1'b0;
		end else begin
			busyPrev <= busy;
		end
	end

	// Enable bit; software reset clears it
	always_ff @(posedge mclk) begin
		if (!rst_b || swrstApply) begin
			enabled <= 1'b0;
		end else if (applyNow && syncCause == CAUSE_ENABLE) begin
			enabled <= pendValue[`BIT_ENABLE];
		end
	end

	// Of the two resets, only a hard reset clears run-in-halt
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			runInHalt <= 1'b0;
		end else if (wrEn && regHit(paddr, `IDX_HALT)) begin
			runInHalt <= pwdata[`BIT_RUN_HALT];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b || swrstApply) begin
			rateTrim <= `RST_BYTE;
		end else if (applyNow && syncCause == CAUSE_TRIM) begin
			rateTrim <= pendValue[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b || swrstApply) begin
			alarmZero <= `RST_WORD;
		end else if (wrEn && regHit(paddr, `IDX_ALARM)) begin
			alarmZero <= pwdata;
		end
	end

	// Counter; a committed write takes the tick over from counting
	always_ff @(posedge mclk) begin
		if (!rst_b || swrstApply) begin
			count <= `RST_WORD;
		end else if (applyNow && syncCause == CAUSE_COUNT) begin
			count <= pendValue;
		end else if (counterTick && counting) begin
			count <= count + 32'h0000_0001;
		end
	end

	// Events seen on one tick become flags on the next tick
	always_ff @(posedge mclk) begin
		if (!rst_b || swrstApply) begin
			ovfPend   <= 1'b0;
			alarmPend <= 1'b0;
		end else if (counterTick) begin
			ovfPend   <= counting && (count == 32'hffff_ffff);
			alarmPend <= counting && (count == alarmZero);
		end
	end

	always_comb begin
		flagSet                 = `RST_BYTE;
		flagSet[`BIT_OVF]        = counterTick && ovfPend;
		flagSet[`BIT_ALARM_ZERO] = counterTick && alarmPend;
		flagSet[`BIT_SYNC_RDY]   = busyPrev && !busy && !quietCause;
	end

	// Write one clears, zero keeps; a set in the same cycle wins
	always_ff @(posedge mclk) begin
		if (!rst_b || swrstApply) begin
			flags <= `RST_BYTE;
		end else if (wrEn && regHit(paddr, `IDX_FLAGS)) begin
			flags <= ((flags & ~pwdata[7:0]) | flagSet) & `FLAG_MASK;
		end else begin
			flags <= (flags | flagSet) & `FLAG_MASK;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b || swrstApply) begin
			irqEnable <= `RST_BYTE;
		end else if (wrEn && regHit(paddr, `IDX_IRQ_SET)) begin
			irqEnable <= (irqEnable | pwdata[7:0]) & `FLAG_MASK;
		end else if (wrEn && regHit(paddr, `IDX_IRQ_CLR)) begin
			irqEnable <= irqEnable & ~pwdata[7:0];
		end
	end

	assign irq = |(flags & irqEnable);

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_ovf_event_seen: assert property (
		counterTick && counting && count == 32'hffff_ffff && !swrstApply |=> ovfPend
	) else $error("overflow event not recorded at wrap");

	a_ovf_flag_rise: assert property (
		ovfPend && counterTick && !swrstApply |=> flags[`BIT_OVF]
	) else $error("overflow flag not set one tick after wrap");

	a_ovf_clear_w1c: assert property (
		wrEn && regHit(paddr, `IDX_FLAGS) && pwdata[`BIT_OVF] && !flagSet[`BIT_OVF]
		&& !swrstApply |=> !flags[`BIT_OVF]
	) else $error("overflow flag not cleared by one");

	a_sync_ready_set: assert property (
		$fell(busy) && !quietCause && !swrstApply |=> flags[`BIT_SYNC_RDY]
	) else $error("sync-ready flag missing after busy fell");

	a_sync_quiet_end: assert property (
		$fell(busy) && quietCause && !$past(flags[`BIT_SYNC_RDY]) |=> !flags[`BIT_SYNC_RDY]
	) else $error("sync-ready set after enable or reset");

	a_rdy_clear_w1c: assert property (
		wrEn && regHit(paddr, `IDX_FLAGS) && pwdata[`BIT_SYNC_RDY]
		&& !flagSet[`BIT_SYNC_RDY] |=> !flags[`BIT_SYNC_RDY]
	) else $error("sync-ready flag not cleared by one");

	a_alarm_flag_set: assert property (
		alarmPend && counterTick && !swrstApply |=> flags[`BIT_ALARM_ZERO]
	) else $error("alarm flag not set one tick after match");

	a_alarm_clear: assert property (
		wrEn && regHit(paddr, `IDX_FLAGS) && pwdata[`BIT_ALARM_ZERO]
		&& !flagSet[`BIT_ALARM_ZERO] && !swrstApply |=> !flags[`BIT_ALARM_ZERO]
	) else $error("alarm flag not cleared by one");

	a_zero_keeps_flags: assert property (
		wrEn && regHit(paddr, `IDX_FLAGS) && pwdata[7:0] == 8'h00 && !swrstApply
		|=> flags == ($past(flags | flagSet) & `FLAG_MASK)
	) else $error("writing zero changed a flag");

	a_irq_follows: assert property (
		flags[`BIT_ALARM_ZERO] && irqEnable[`BIT_ALARM_ZERO] |-> irq
	) else $error("interrupt missing with enabled flag");

	a_busy_start: assert property (
		syncStart |=> busy[*2]
	) else $error("busy not raised on transfer start");

	a_busy_end: assert property (
		applyNow |=> !busy
	) else $error("busy still high after commit");

	a_halt_kept: assert property (
		swrstApply |=> runInHalt == $past(runInHalt)
	) else $error("software reset disturbed run-in-halt");

	a_halt_stops: assert property (
		cpuDebugHalt && !runInHalt && !applyNow && !swrstApply |=> $stable(count)
	) else $error("counter moved during debug halt");

	a_halt_runs: assert property (
		enabled && cpuDebugHalt && runInHalt && counterTick && !applyNow
		|=> count == $past(count) + 32'h0000_0001
	) else $error("counter stopped despite run-in-halt");

	a_trim_sign: assert property (
		rateTrim[6:0] != 7'h00 && windowCnt == 7'h00
		|-> curPeriod == (rateTrim[`BIT_SIGN] ? 16'(PRESC_DIV - 1) : 16'(PRESC_DIV + 1))
	) else $error("trim sign applied wrong way");

	a_trim_zero: assert property (
		rateTrim[6:0] == 7'h00 |-> curPeriod == 16'(PRESC_DIV)
	) else $error("period changed with zero trim");

	a_enable_set: assert property (
		wrEn && regHit(paddr, `IDX_IRQ_SET) && pwdata[`BIT_ALARM_ZERO] && !swrstApply
		|=> irqEnable[`BIT_ALARM_ZERO]
	) else $error("enable-set write ignored");

	a_set_wins: assert property (
		flagSet[`BIT_SYNC_RDY] && !swrstApply |=> flags[`BIT_SYNC_RDY]
	) else $error("flag set lost to clear");

	c_overflow: cover property (flagSet[`BIT_OVF]);
	c_sync_ready: cover property (flagSet[`BIT_SYNC_RDY]);
	c_irq_rise: cover property ($rose(irq));
	c_set_and_clear: cover property (
		flagSet[`BIT_ALARM_ZERO] && wrEn && regHit(paddr, `IDX_FLAGS)
	);

endmodule

// [tb_rtc_flags_status_trim.sv]
/*
 Self-checking bench for the real-time counter register block.
 Assumes the defs header and package are compiled first; prescaler shortened.
*/
`timescale 1ns/1ps
`include "rtc_flags_status_trim_defs.svh"
module tb_rtc_flags_status_trim;
	localparam int DIV = 8;
	logic        mclk, rst_b, psel, penable, pwrite, cpuDebugHalt;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv, a, b;
	logic        pready, pslverr, irq, err;
	int          n_errors, checked, cycles, seed;
	logic [5:0]  regs[6] = '{`IDX_FLAGS, `IDX_SYNC, `IDX_HALT, `IDX_TRIM, `IDX_COUNT, `IDX_IRQ_SET};
	logic [7:0]  trims[3] = '{8'h00, 8'h7f, 8'hff};
	int          lo[3] = '{50, 44, 56};
	int          hi[3] = '{51, 46, 58};

	rtc_flags_status_trim #(.PRESC_DIV(DIV)) i_dut (
		.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpuDebugHalt(cpuDebugHalt), .irq(irq)
	);

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic conclude();
		if (n_errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Ceiling well above the roughly two thousand cycles the sequence needs
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Flags left after a write-one-to-clear of d
	function automatic logic [7:0] keptFlags(input logic [7:0] f, input logic [7:0] d);
		return f & ~d;
	endfunction

	// Request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
		int k;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		check("pready", pready, 1'b1);
		rv = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] x, input logic [31:0] d);
		apb(1'b1, x, d);
	endtask

	task automatic rd(input logic [5:0] x);
		apb(1'b0, x, 32'h0000_0000);
	endtask

	task automatic rdc(input logic [5:0] x, input logic [31:0] exp, input string what);
		rd(x);
		check(what, rv, exp);
	endtask

	task automatic irqIs(input logic exp);
		@(posedge mclk);
		check("irq", irq, exp);
	endtask

	task automatic waitSync();
		int k;
		k = 0;
		do begin
			rd(`IDX_SYNC);
			k++;
		end while (rv[`BIT_BUSY] !== 1'b0 && k < 40);
		check("busy cleared", rv, 32'h0000_0000);
	endtask

	task automatic pollFlag(input int pos);
		int k;
		k = 0;
		do begin
			rd(`IDX_FLAGS);
			k++;
		end while (rv[pos] !== 1'b1 && k < 60);
		check("flag set", rv[pos], 1'b1);
	endtask

	// Counter advance over a fixed gap of len+3 cycles between samples
	task automatic gap(input int len);
		rd(`IDX_COUNT);
		a = rv;
		repeat (len) @(posedge mclk);
		rd(`IDX_COUNT);
		b = rv;
	endtask

	initial begin
		seed = 35320;
		n_errors = 0;
		checked = 0;
		cycles = 0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		cpuDebugHalt = 1'b0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		foreach (regs[j]) rdc(regs[j], 32'h0000_0000, "reset value");
		check("irq idle", irq, 1'b0);
		rd(6'h01);
		check("unmapped error", err, 1'b1);
		check("unmapped data", rv, 32'h0000_0000);
		wr(`IDX_SYNC, 32'h0000_00ff);
		rdc(`IDX_SYNC, 32'h0000_0000, "status read only");
		// Software reset keeps the halt control
		wr(`IDX_HALT, 32'h0000_0001);
		wr(`IDX_CTRL, 32'h0000_0001);
		waitSync();
		rdc(`IDX_HALT, 32'h0000_0001, "halt after swrst");
		rdc(`IDX_FLAGS, 32'h0000_0000, "quiet swrst");
		// Alarm parked far away so counting from zero raises no event
		wr(`IDX_ALARM, 32'hffff_0000);
		wr(`IDX_CTRL, 32'h0000_0002);
		rd(`IDX_SYNC);
		check("busy set", rv[`BIT_BUSY], 1'b1);
		waitSync();
		rdc(`IDX_FLAGS, 32'h0000_0000, "quiet enable");
		foreach (trims[j]) begin
			wr(`IDX_TRIM, {24'h00_0000, trims[j]});
			waitSync();
			rdc(`IDX_FLAGS, 32'h0000_0040, "sync ready");
			check("irq masked", irq, 1'b0);
			a = $random(seed) & 32'hffff_ffbf;
			wr(`IDX_FLAGS, a);
			rdc(`IDX_FLAGS, {24'h00_0000, keptFlags(8'h40, a[7:0])}, "flag kept");
			wr(`IDX_FLAGS, 32'h0000_0040);
			rdc(`IDX_FLAGS, 32'h0000_0000, "sync ready cleared");
			rdc(`IDX_TRIM, {24'h00_0000, trims[j]}, "trim value");
			gap(400);
			check("rate", (b - a) >= lo[j] && (b - a) <= hi[j], 1'b1);
		end
		wr(`IDX_TRIM, 32'h0000_0000);
		waitSync();
		wr(`IDX_FLAGS, 32'h0000_0040);
		cpuDebugHalt <= 1'b1;
		wr(`IDX_HALT, 32'h0000_0000);
		gap(40);
		check("halted", b, a);
		wr(`IDX_HALT, 32'h0000_0001);
		gap(40);
		check("run in halt", (b - a) >= 5 && (b - a) <= 6, 1'b1);
		cpuDebugHalt <= 1'b0;
		wr(`IDX_IRQ_SET, 32'h0000_0001);
		rdc(`IDX_IRQ_SET, 32'h0000_0001, "enable set");
		rd(`IDX_COUNT);
		wr(`IDX_ALARM, rv + 3 + ($random(seed) & 7));
		pollFlag(`BIT_ALARM_ZERO);
		check("irq alarm", irq, 1'b1);
		wr(`IDX_IRQ_SET, 32'h0000_0000);
		irqIs(1'b1);
		wr(`IDX_IRQ_CLR, 32'h0000_0001);
		irqIs(1'b0);
		wr(`IDX_IRQ_SET, 32'h0000_0001);
		irqIs(1'b1);
		wr(`IDX_FLAGS, 32'h0000_0001);
		irqIs(1'b0);
		rdc(`IDX_FLAGS, 32'h0000_0000, "alarm cleared");
		wr(`IDX_IRQ_SET, 32'h0000_0080);
		wr(`IDX_COUNT, 32'hffff_fffc);
		waitSync();
		pollFlag(`BIT_OVF);
		irqIs(1'b1);
		wr(`IDX_FLAGS, 32'h0000_0080);
		rd(`IDX_FLAGS);
		check("overflow cleared", rv[`BIT_OVF], 1'b0);
		irqIs(1'b0);
		// Full reset does clear the halt control
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		rdc(`IDX_HALT, 32'h0000_0000, "halt after reset");
		conclude();
	end
endmodule
